// ---- rtl/tla_alarm.sv ----
// Limit checking, status flags, alarm latch and comparator outputs
//
// Behaviour
// - High is >, low is <=, sets flag
// - Over-temperature sets bit 1/0, drives comparator low
// - Second comparator follows only the high limits
// - One hysteresis for both, default ten degrees
// - Comparator releases at limit minus hysteresis
// - Comparator flags clear themselves at limit minus hysteresis
// - Limits kept unchanged when range switches
// - Status bit 7 shows converter busy
// - Status bits 6..2: LH, LL, RH, RL, open
// - With pin 6 as interrupt, any flag 6..2 sets latch, interrupt low
// - Flags sticky; status read clears if gone
// - Latch clears on address read when clean
// - Offset is 10-bit signed, high plus two
// - Offset added to remote, zero at reset
// - One-shot write in standby starts one conversion
// - Fault count code gives one to four
// - Fault count defaults to one, bit 7 timeout
// - Enabled bus timeout after 25 ms idle
// - Config bit 5 selects pin 6 function
// - Config bit 7 masks interrupt output only
`timescale 1ns/10ps
module tla_alarm #(
    parameter int unsigned TMO_CYCLES = tla_pkg::TMO_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port from the serial engine
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic addr_read_i,
    // Serial engine activity for the timeout
    input wire logic bus_busy_i,
    input wire logic bus_act_i,
    output logic bus_timeout_o,
    // Converter results
    input wire logic res_vld_i,
    input wire logic [7:0] local_temp_i,
    input wire logic [9:0] remote_meas_i,
    input wire logic remote_open_i,
    input wire logic busy_i,
    // Converter control
    output logic standby_o,
    output logic range_ext_o,
    output logic oneshot_start_o,
    // Alarm pins
    output logic overtemp_cmp_n_o,
    output logic limit_irq_n_o,
    output logic second_overtemp_n_o
);
    import tla_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] cfg; // Configuration
        logic [7:0] lhi; // Local high limit
        logic [7:0] llo; // Local low limit
        logic [7:0] rhi; // Remote high limit, integer
        logic [7:0] rlo; // Remote low limit, integer
        logic [1:0] rhil; // Remote high limit, fraction
        logic [1:0] rlol; // Remote low limit, fraction
        logic [7:0] lth; // Local overtemp limit
        logic [7:0] rth; // Remote overtemp limit
        logic [7:0] hyst; // Shared hysteresis
        logic [7:0] cflt; // Fault count and timeout enable
        logic [7:0] offh; // Offset high byte
        logic [1:0] offl; // Offset low byte, upper two bits
        logic [7:0] lval; // Last local result
        logic [9:0] rval; // Last corrected remote result
        logic [4:0] flags; // Sticky status bits 6..2
        logic [4:0] cond; // Raw out-of-limit of last result
        logic [1:0] th; // Overtemp comparators, remote/local
        logic [1:0] t2; // High-limit comparators, remote/local
        logic latch; // Interrupt latch
        logic [7:0] rdata; // Read data
        tla_shot_e shot; // One-shot state
        logic start; // One-shot start pulse
        logic [19:0] tmo; // Bus inactivity count
        logic tmo_p; // Timeout pulse
    } tla_st_s;

    tla_st_s st_ff;
    tla_st_s nxt_st;

    // Hysteresis comparator in quarter degrees, so remote fractions count
    function automatic logic tla_hyst(input logic cur,
                                      input logic [9:0] t,
                                      input logic [7:0] lim,
                                      input logic [7:0] hy);
        logic signed [11:0] rel;
        rel = $signed({2'h0, lim, 2'h0}) - $signed({2'h0, hy, 2'h0});
        if (t > {lim, 2'h0}) begin
            return 1'b1;
        end
        if ($signed({2'h0, t}) <= rel) begin
            return 1'b0;
        end
        return cur;
    endfunction

    // ==========================================================
    // Remote offset correction, clamped to the result range
    logic [9:0] off; // Offset, 8.2 two's complement
    logic signed [11:0] rsum; // Raw sum
    logic [9:0] rcorr; // Corrected remote result
    assign off = {st_ff.offh, st_ff.offl};
    assign rsum = $signed({2'h0, remote_meas_i}) +
                  $signed({{2{off[9]}}, off});
    // Clamp rather than wrap so a big offset cannot fake an alarm
    assign rcorr = (rsum < 0) ? 10'h000 :
                   (rsum > 12'sh3FF) ? 10'h3FF : rsum[9:0];

    // ==========================================================
    // Limit checks and consecutive-fault filters
    logic [4:0] cond; // Out-of-limit conditions, bit order as flags
    logic [4:0] trip; // Filtered conditions
    logic [2:0] need; // Required run length
    assign cond[4] = local_temp_i > st_ff.lhi;
    assign cond[3] = local_temp_i <= st_ff.llo;
    assign cond[2] = rcorr > {st_ff.rhi, st_ff.rhil};
    assign cond[1] = rcorr <= {st_ff.rlo, st_ff.rlol};
    assign cond[0] = remote_open_i;
    assign need = tla_need(st_ff.cflt[CFLT_LSB +: 3]);

    // One filter per check so runs are tracked independently
    for (genvar i = 0; i < 5; i++) begin : g_flt
        tla_fault_filter u_flt (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .meas_vld_i(res_vld_i),
            .out_lim_i(cond[i]),
            .need_i(need),
            .trip_o(trip[i])
        );
    end

    // Mode decode
    logic pin6_cmp; // Pin 6 is the second comparator
    logic stat_rd; // Status register read
    assign pin6_cmp = st_ff.cfg[CFG_PIN6];
    assign stat_rd = reg_rd_i && (reg_addr_i == A_STAT);

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.start = 1'b0;
        nxt_st.tmo_p = 1'b0;
        // Register writes; limits are stored as written, never
        // rescaled when the range bit changes
        if (reg_wr_i) begin
            case (reg_addr_i)
                A_CFG_W: nxt_st.cfg = reg_wdata_i;
                A_LHI_W: nxt_st.lhi = reg_wdata_i;
                A_LLO_W: nxt_st.llo = reg_wdata_i;
                A_RHI_W: nxt_st.rhi = reg_wdata_i;
                A_RLO_W: nxt_st.rlo = reg_wdata_i;
                A_RHIL: nxt_st.rhil = reg_wdata_i[7:6];
                A_RLOL: nxt_st.rlol = reg_wdata_i[7:6];
                A_OFFH: nxt_st.offh = reg_wdata_i;
                A_OFFL: nxt_st.offl = reg_wdata_i[7:6];
                A_RTH: nxt_st.rth = reg_wdata_i;
                A_LTH: nxt_st.lth = reg_wdata_i;
                A_HYST: nxt_st.hyst = reg_wdata_i;
                A_CFLT: nxt_st.cflt = reg_wdata_i;
                // One-shot data is dropped; others unmapped
                default: nxt_st.cfg = st_ff.cfg;
            endcase
        end
        // Read data, unmapped addresses read zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                A_LVAL: nxt_st.rdata = st_ff.lval;
                A_RVALH: nxt_st.rdata = st_ff.rval[9:2];
                A_RVALL: nxt_st.rdata = {st_ff.rval[1:0], 6'h00};
                A_STAT: nxt_st.rdata = {busy_i, st_ff.flags,
                                        st_ff.th};
                A_CFG_R: nxt_st.rdata = st_ff.cfg;
                A_LHI_R: nxt_st.rdata = st_ff.lhi;
                A_LLO_R: nxt_st.rdata = st_ff.llo;
                A_RHI_R: nxt_st.rdata = st_ff.rhi;
                A_RLO_R: nxt_st.rdata = st_ff.rlo;
                A_RHIL: nxt_st.rdata = {st_ff.rhil, 6'h00};
                A_RLOL: nxt_st.rdata = {st_ff.rlol, 6'h00};
                A_OFFH: nxt_st.rdata = st_ff.offh;
                A_OFFL: nxt_st.rdata = {st_ff.offl, 6'h00};
                A_RTH: nxt_st.rdata = st_ff.rth;
                A_LTH: nxt_st.rdata = st_ff.lth;
                A_HYST: nxt_st.rdata = st_ff.hyst;
                A_CFLT: nxt_st.rdata = st_ff.cflt;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // New results update values and comparators
        if (res_vld_i) begin
            nxt_st.lval = local_temp_i;
            nxt_st.rval = rcorr;
            nxt_st.cond = cond;
            nxt_st.th[0] = tla_hyst(st_ff.th[0], {local_temp_i, 2'h0},
                                    st_ff.lth, st_ff.hyst);
            nxt_st.th[1] = tla_hyst(st_ff.th[1], rcorr,
                                    st_ff.rth, st_ff.hyst);
            nxt_st.t2[0] = tla_hyst(st_ff.t2[0], {local_temp_i, 2'h0},
                                    st_ff.lhi, st_ff.hyst);
            nxt_st.t2[1] = tla_hyst(st_ff.t2[1], rcorr,
                                    st_ff.rhi, st_ff.hyst);
        end
        // Sticky flags: read clears only gone conditions, set wins
        nxt_st.flags = (st_ff.flags &
                        ~({5{stat_rd}} & ~st_ff.cond)) | trip;
        // Latch ignores status reads; address read clears when clean
        if (addr_read_i && (st_ff.flags == 5'h00) &&
            (st_ff.cond == 5'h00)) begin
            nxt_st.latch = 1'b0;
        end
        if (!pin6_cmp && (st_ff.flags != 5'h00)) begin
            nxt_st.latch = 1'b1;
        end
        // One-shot sequencer
        case (st_ff.shot)
            TLA_IDLE: begin
                if (reg_wr_i && (reg_addr_i == A_SHOT) &&
                    st_ff.cfg[CFG_STBY]) begin
                    nxt_st.start = 1'b1;
                    nxt_st.shot = TLA_SHOT;
                end
            end
            TLA_SHOT: begin
                // Back to standby after the result arrives
                if (res_vld_i) begin
                    nxt_st.shot = TLA_IDLE;
                end
            end
            default: nxt_st.shot = TLA_IDLE;
        endcase
        // Bus inactivity timer, only inside a transaction
        if (st_ff.cflt[CFLT_TMO] && bus_busy_i && !bus_act_i) begin
            if (st_ff.tmo == 20'(TMO_CYCLES - 1)) begin
                nxt_st.tmo = 20'h00000;
                nxt_st.tmo_p = 1'b1;
            end else begin
                nxt_st.tmo = st_ff.tmo + 20'h00001;
            end
        end else begin
            nxt_st.tmo = 20'h00000;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.cfg <= RST_CFG;
            st_ff.lhi <= RST_HI;
            st_ff.llo <= RST_LO;
            st_ff.rhi <= RST_HI;
            st_ff.rlo <= RST_LO;
            st_ff.lth <= RST_TH;
            st_ff.rth <= RST_TH;
            st_ff.hyst <= RST_HYST;
            st_ff.cflt <= RST_CFLT;
            st_ff.offh <= RST_OFF;
            st_ff.shot <= TLA_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = st_ff.rdata;
    assign bus_timeout_o = st_ff.tmo_p;
    assign standby_o = st_ff.cfg[CFG_STBY];
    assign range_ext_o = st_ff.cfg[CFG_RANGE];
    assign oneshot_start_o = st_ff.start;
    assign overtemp_cmp_n_o = ~|st_ff.th;
    // Only the function selected for pin 6 is ever pulled low
    assign second_overtemp_n_o = !(pin6_cmp && |st_ff.t2);
    assign limit_irq_n_o = !(!pin6_cmp && !st_ff.cfg[CFG_MASK] &&
                             st_ff.latch);

    // ==========================================================
    // Assertions
    sequence s_lh_fault;
        res_vld_i && cond[4] && (need == 3'h1);
    endsequence
    sequence s_irq_low;
        st_ff.latch ##0 !limit_irq_n_o;
    endsequence

    property p_high_sets;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_lh_fault |=> st_ff.flags[4];
    endproperty
    a_high_sets: assert property (p_high_sets)
        else $error("local high fault did not set flag");

    property p_low_eq;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        res_vld_i && (local_temp_i == st_ff.llo) && (need == 3'h1)
        |=> st_ff.flags[3];
    endproperty
    a_low_eq: assert property (p_low_eq)
        else $error("equal to low limit not flagged");

    property p_overtemp_cmp_n;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        res_vld_i && (local_temp_i > st_ff.lth) |=> !overtemp_cmp_n_o;
    endproperty
    a_overtemp_cmp_n: assert property (p_overtemp_cmp_n)
        else $error("comparator not asserted above limit");

    property p_hyst_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_ff.th[0] && res_vld_i && ($signed({2'h0, local_temp_i}) >
            $signed({2'h0, st_ff.lth}) - $signed({2'h0, st_ff.hyst}))
        |=> st_ff.th[0];
    endproperty
    a_hyst_hold: assert property (p_hyst_hold)
        else $error("comparator released inside hysteresis");

    property p_irq;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_ff.flags != 5'h00) && !pin6_cmp && !st_ff.cfg[CFG_MASK]
        && !reg_wr_i ##1 !pin6_cmp |-> s_irq_low;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised for set flag");

    property p_sticky;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_ff.flags[4] && !stat_rd |=> st_ff.flags[4];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without status read");

    property p_latch_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        st_ff.latch && !addr_read_i |=> st_ff.latch;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch cleared without address read");

    property p_oneshot;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && (reg_addr_i == A_SHOT) && st_ff.cfg[CFG_STBY] &&
        (st_ff.shot == TLA_IDLE) |=> oneshot_start_o ##1 !oneshot_start_o;
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot start missing or too long");

    property p_t2;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        res_vld_i && pin6_cmp && !reg_wr_i && (local_temp_i > st_ff.lhi)
        |=> !second_overtemp_n_o && limit_irq_n_o;
    endproperty
    a_t2: assert property (p_t2)
        else $error("second comparator not asserted");

endmodule

// ---- shared/tla_pkg.sv ----
// Constants, types and helpers shared by the temperature limit alarm logic
package tla_pkg;

    // ==========================================================
    // Register addresses (read and write ports differ for some)
    localparam logic [7:0] A_LVAL = 8'h00; // Local result
    localparam logic [7:0] A_RVALH = 8'h01; // Remote result, integer
    localparam logic [7:0] A_STAT = 8'h02; // alarm_status
    localparam logic [7:0] A_CFG_R = 8'h03; // Configuration, read
    localparam logic [7:0] A_LHI_R = 8'h05; // Local high limit, read
    localparam logic [7:0] A_LLO_R = 8'h06; // Local low limit, read
    localparam logic [7:0] A_RHI_R = 8'h07; // Remote high limit, read
    localparam logic [7:0] A_RLO_R = 8'h08; // Remote low limit, read
    localparam logic [7:0] A_CFG_W = 8'h09; // Configuration, write
    localparam logic [7:0] A_LHI_W = 8'h0B; // Local high limit, write
    localparam logic [7:0] A_LLO_W = 8'h0C; // Local low limit, write
    localparam logic [7:0] A_RHI_W = 8'h0D; // Remote high limit, write
    localparam logic [7:0] A_RLO_W = 8'h0E; // Remote low limit, write
    localparam logic [7:0] A_SHOT = 8'h0F; // single_shot_trigger
    localparam logic [7:0] A_RVALL = 8'h10; // Remote result, fraction
    localparam logic [7:0] A_OFFH = 8'h11; // remote_offset_high
    localparam logic [7:0] A_OFFL = 8'h12; // remote_offset_low
    localparam logic [7:0] A_RHIL = 8'h13; // Remote high limit, fraction
    localparam logic [7:0] A_RLOL = 8'h14; // Remote low limit, fraction
    localparam logic [7:0] A_RTH = 8'h19; // Remote overtemp limit
    localparam logic [7:0] A_LTH = 8'h20; // Local overtemp limit
    localparam logic [7:0] A_HYST = 8'h21; // comparator_hysteresis
    localparam logic [7:0] A_CFLT = 8'h22; // fault_count_filter

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_HI = 8'h55;
    localparam logic [7:0] RST_LO = 8'h00;
    localparam logic [7:0] RST_TH = 8'h55;
    localparam logic [7:0] RST_HYST = 8'h0A;
    localparam logic [7:0] RST_CFLT = 8'h01;
    localparam logic [7:0] RST_OFF = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CFG_MASK = 7; // Interrupt output disable
    localparam int CFG_STBY = 6; // Standby
    localparam int CFG_PIN6 = 5; // 1: second comparator on pin 6
    localparam int CFG_RANGE = 2; // Extended measurement range
    localparam int CFLT_TMO = 7; // Bus timeout enable
    localparam int CFLT_LSB = 1; // Fault count code, bits 3:1
    localparam int ST_BUSY = 7; // Converter busy in status

    // ==========================================================
    // Timing
    localparam int TMO_MS = 25; // Bus inactivity timeout, ms
    localparam int CLK_HZ = 40_000_000; // Reference clock
    localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        TLA_IDLE = 2'b01, // Waiting
        TLA_SHOT = 2'b10 // One conversion requested
    } tla_shot_e;

    // Required run length from the fault count code (1..4)
    function automatic logic [2:0] tla_need(input logic [2:0] code);
        return 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'h1;
    endfunction

endpackage

// ---- rtl/tla_fault_filter.sv ----
// Consecutive out-of-limit run counter for one limit check
`timescale 1ns/10ps
module tla_fault_filter (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Measurement
    input wire logic meas_vld_i,
    input wire logic out_lim_i,
    input wire logic [2:0] need_i,
    // Result
    output logic trip_o
);
    import tla_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] cnt; // Unbroken out-of-limit run, saturates
    } tla_flt_s;

    tla_flt_s st_ff;
    tla_flt_s nxt_st;
    logic [2:0] run; // Run length including this measurement

    // Next state
    always_comb begin
        nxt_st = st_ff;
        run = (st_ff.cnt == 3'h4) ? 3'h4 : st_ff.cnt + 3'h1;
        if (meas_vld_i) begin
            // In-limit result breaks the run
            nxt_st.cnt = out_lim_i ? run : 3'h0;
        end
    end

    // Trip once the run reaches the programmed count
    assign trip_o = meas_vld_i && out_lim_i && (run >= need_i);

    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// ---- sim/tla_host_model.sv ----
// Host model driving the register port the way the serial engine does
`timescale 1ns/10ps
module tla_host_model (
    // Clock
    input wire logic clk_i,
    // Register port towards the alarm logic
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic addr_read_o,
    input wire logic [7:0] rdata_i
);
    // ==========================================================
    // Idle state at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_read_o = 1'b0;
    end
    // One byte write; the write strobe is held for one clock
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // Stale data inverted so nothing leans on a held value
        wdata_o <= ~d;
    endtask
    // One byte read; data taken once the registered answer lands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
    // Alert service: host reads the device address
    task automatic svc();
        @(posedge clk_i);
        addr_read_o <= 1'b1;
        @(posedge clk_i);
        addr_read_o <= 1'b0;
    endtask
endmodule

// ---- sim/tla_alarm_tb_top.sv ----
// Testbench: limit and alarm logic against a behavioural model
`timescale 1ns/10ps
module tla_alarm_tb_top;
    import tla_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd, aread, tmo, stby, rext, shot, cmp_n, irq_n, t2_n;
    logic rvld = 1'b0, ropen = 1'b0, busy = 1'b0, bbusy = 1'b0;
    logic bact = 1'b0;
    logic [7:0] ltemp = 8'h00;
    logic [9:0] rmeas = 10'h000;
    integer seed = 32'hE36F7E83;
    int failures = 0, check_count = 0;
    // Model: settings, per-bit runs, sticky flags, comparator states
    int hy = 10, need = 1, off = 0, cfg = 0, latch = 0;
    int raw[7], run[7], flg[7], th[2], t2[2];
    always #12.5 ref_clk_i = ~ref_clk_i;
    // ==========================================================
    // Design and host
    tla_alarm #(.TMO_CYCLES(16)) tla_alarm_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .addr_read_i(aread), .bus_busy_i(bbusy),
        .bus_act_i(bact), .bus_timeout_o(tmo), .res_vld_i(rvld),
        .local_temp_i(ltemp), .remote_meas_i(rmeas),
        .remote_open_i(ropen), .busy_i(busy), .standby_o(stby),
        .range_ext_o(rext), .oneshot_start_o(shot),
        .overtemp_cmp_n_o(cmp_n), .limit_irq_n_o(irq_n),
        .second_overtemp_n_o(t2_n));
    tla_host_model tla_host_model_inst (
        .clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .addr_read_o(aread), .rdata_i(rdata));
    // ==========================================================
    // Checking and reporting
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic done(input string s);
        $display("test %s ended, %0d checks", s, check_count);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Comparator with hysteresis: trips above, releases at lim - hys
    function automatic int hys(int s, int t, int l, int h);
        return t > l ? 1 : (t <= l - h ? 0 : s);
    endfunction
    // Pins from model state; unselected pin 6 function stays high
    task automatic pins();
        check(cmp_n, !(th[0] || th[1]));
        check(irq_n, !(latch && !cfg[7] && !cfg[5]));
        check(t2_n, !(cfg[5] && (t2[0] || t2[1])));
    endtask
    // One conversion result; remote in quarter degrees
    task automatic res(input int l, input int r, input int op);
        int rc;
        rc = r + off;
        rc = rc < 0 ? 0 : (rc > 1023 ? 1023 : rc);
        @(posedge ref_clk_i);
        rvld <= 1'b1;
        ltemp <= 8'(l);
        rmeas <= 10'(r);
        ropen <= op[0];
        @(posedge ref_clk_i);
        rvld <= 1'b0;
        raw = '{0, 0, op, rc <= 0, rc > 340, l <= 0, l > 85};
        for (int i = 2; i < 7; i++) begin
            run[i] = raw[i] ? run[i] + 1 : 0;
            flg[i] |= int'(run[i] >= need);
        end
        th[0] = hys(th[0], l, 85, hy);
        th[1] = hys(th[1], rc, 340, hy * 4);
        t2[0] = hys(t2[0], l, 85, hy);
        t2[1] = hys(t2[1], rc, 340, hy * 4);
        if (!cfg[5] && flg.or() != 0) latch = 1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        pins();
    endtask
    // Status read; flags whose cause is gone drop afterwards
    task automatic stat();
        logic [7:0] e;
        e = {busy, 5'h00, th[1][0], th[0][0]};
        for (int i = 2; i < 7; i++) e[i] = flg[i][0];
        tla_host_model_inst.rd(A_STAT, got);
        check(got, e);
        for (int i = 2; i < 7; i++) if (!raw[i]) flg[i] = 0;
    endtask
    task automatic svc();
        tla_host_model_inst.svc();
        if (flg.or() == 0 && raw.or() == 0) latch = 0;
        #1;
        pins();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        tla_host_model_inst.rd(a, got);
        check(got, e);
    endtask
    task automatic cw(input int v);
        tla_host_model_inst.wr(A_CFG_W, 8'(v));
        cfg = v;
        @(posedge ref_clk_i);
        #1;
        check(stby, cfg[6]);
        check(rext, cfg[2]);
    endtask
    // Quiet result, then flags and latch cleared by the host
    task automatic clr();
        res(32, 128, 0);
        stat();
        stat();
        svc();
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rdc(A_HYST, 8'h0A);
        rdc(A_CFLT, 8'h01);
        rdc(A_OFFH, 8'h00);
        cw(4);
        rdc(A_LHI_R, 8'h55);
        cw(0);
        res(0, 0, 1);
        stat();
        clr();
        done("reset and defaults");
        // Random results, hysteresis and offset changed halfway
        for (int k = 0; k < 40; k++) begin
            if (k == 20) begin
                tla_host_model_inst.wr(A_HYST, 8'h04);
                hy = 4;
                tla_host_model_inst.wr(A_OFFH, 8'hFC);
                off = -16;
                rdc(A_OFFH, 8'hFC);
            end
            @(posedge ref_clk_i);
            busy <= 1'($random(seed));
            res(60 + $unsigned($random(seed)) % 40,
                4 * (60 + $unsigned($random(seed)) % 40),
                int'($unsigned($random(seed)) % 8 == 0));
            stat();
            if (k % 4 == 3) svc();
        end
        clr();
        done("random limits");
        // Fault filter codes 001x, 011x, 111x with a broken run first
        for (int c = 1; c < 4; c++) begin
            tla_host_model_inst.wr(A_CFLT, 8'((1 << (c + 1)) - 2));
            need = c + 1;
            res(100, 160, 0);
            res(32, 160, 0);
            repeat (need) res(100, 160, 0);
            clr();
        end
        tla_host_model_inst.wr(A_CFLT, 8'h00);
        need = 1;
        done("fault filter");
        // Remote one quarter degree over the overtemp limit after the offset must trip
        res(32, 357, 0);
        cw(128);
        res(100, 160, 0);
        clr();
        cw(32);
        res(0, 160, 0);
        res(100, 160, 0);
        res(32, 160, 0);
        stat();
        stat();
        cw(0);
        svc();
        done("mask and second comparator");
        // One-shot in standby; written data is not kept
        cw(64);
        tla_host_model_inst.wr(A_SHOT, 8'h5A);
        got = 8'h00;
        for (int n = 0; n < 4 && !got[0]; n++) begin
            #1;
            got[0] = shot;
            @(posedge ref_clk_i);
        end
        check(got[0], 1'b1);
        res(32, 160, 0);
        rdc(A_SHOT, 8'h00);
        cw(0);
        done("one-shot");
        // Bus timeout with the enable bit set
        tla_host_model_inst.wr(A_CFLT, 8'h80);
        @(posedge ref_clk_i);
        bbusy <= 1'b1;
        got = 8'h00;
        // Pulse due after exactly 16 counted cycles, seen at n = 15
        for (int n = 0; n < 40 && !got[0]; n++) begin
            @(posedge ref_clk_i);
            #1;
            got = {7'(n), tmo};
        end
        check(got, 8'h1F);
        @(posedge ref_clk_i);
        bbusy <= 1'b0;
        done("bus timeout");
        wrap_up();
    end
endmodule
